// *** design/xpc_expansion_ctrl.sv ***
`timescale 1ns/10ps
// How it works
// - output enable bit drives or floats realtime pin
// - bit 6 picks reference or sync pulse
// - sync pulse width and fine delay programmable
// - bits 5:4 route vertical reference output
// - bit 3 picks inverted lock or fast lock
// - format 000 passes stream with timing codes
// - format 001 blanks video outside gate window
// - format 010 drops timing reference codes
// - format 100 bypasses converter bits 8..1
// - format 101 bypasses converter bits 7..0
// - format 111 splits one converter word
// - half-rate reference toggles every pixel tick
// - horizontal reference marks each active line
module xpc_expansion_ctrl
   import xpc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port from the serial control front end
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // settings held in neighbouring registers
   input wire logic [7:0] hsync_begin,
   input wire logic [7:0] hsync_stop,
   input wire logic [1:0] hsync_fine_delay,
   input wire logic [8:0] gate_start_line,
   input wire logic [8:0] gate_stop_line,
   input wire logic gate_position_select,
   // video timing from the decoder core
   input wire logic pix_en,
   input wire logic horiz_valid_ref,
   input wire logic vertical_sync_signal,
   input wire logic field_identifier,
   input wire logic [8:0] line_number,
   input wire logic horiz_lock_status,
   input wire logic fast_lock_indicator,
   input wire logic rt_control_data,
   // decoded byte stream
   input wire logic [7:0] vid_data,
   input wire logic vid_valid,
   input wire logic vid_timing_code,
   output logic vid_ready,
   // converter words for bypass
   input wire logic [8:0] converter_one,
   input wire logic [8:0] converter_two,
   input wire logic [8:0] converter_three,
   input wire logic [8:0] converter_four,
   input wire logic converter_pair_high,
   input wire logic two_converters,
   // expansion port and realtime pin
   input wire logic exp_ready,
   output logic [7:0] exp_data_bus,
   output logic exp_data_valid,
   output logic exp_horiz_ref_out,
   output logic exp_vert_ref_out,
   output logic horiz_lock_indicator,
   output logic realtime_control_out,
   output logic realtime_out_oe,
   output logic half_rate_reference
);

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0] ctrl, next_ctrl;            // the control register
   logic [2:0] pix_cnt, next_pix_cnt;      // divider of pixel ticks
   logic horiz_valid_ref_prev, next_horiz_valid_ref_prev;        // for line start edge
   logic [7:0] hs_step, next_hs_step;      // eighth-rate steps in line
   logic [2:0] hs_pipe, next_hs_pipe;      // half-rate delay taps
   logic blank_phase, next_blank_phase;    // chroma/luma of blanking
   logic [7:0] next_reg_rdata;
   logic next_reg_rvalid;
   logic [7:0] next_exp_data;
   logic next_exp_valid, next_horiz_valid_ref_out, next_vref_out, next_lock;
   logic next_rt_out, next_rt_oe, next_half;

   // combinational helpers
   logic [2:0] fmt;
   logic line_start, eighth_tick, half_tick, hs_raw, hs_sel, gate_on;
   logic [8:0] conv_lo, conv_hi;

   xpc_fifo_if #(.WIDTH(FIFO_WIDTH)) link ();

   // buffer between the format selector and the port pins
   xpc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .link(link.fifo)
   );

   ////////////////////////////////////////////////////////////////////////
   // next values of every flop of this module
   always_comb begin
      fmt = ctrl[FMT_HI:FMT_LO];
      line_start = horiz_valid_ref && !horiz_valid_ref_prev;
      eighth_tick = pix_en && (pix_cnt == EIGHTH_LAST);
      half_tick = pix_en && pix_cnt[0];
      hs_raw = (hs_step >= hsync_begin) && (hs_step < hsync_stop);
      // fine delay slides the pulse by whole half-rate steps
      hs_sel = (hsync_fine_delay == 2'h0) ? hs_raw :
               hs_pipe[hsync_fine_delay - 2'h1];
      // position select widens the window to include the stop line
      gate_on = (line_number >= gate_start_line) &&
                ((line_number < gate_stop_line) ||
                 (gate_position_select && line_number == gate_stop_line));
      conv_lo = converter_pair_high ? converter_three : converter_one;
      conv_hi = converter_pair_high ? converter_four : converter_two;

      // register port: reads answer one cycle later
      next_ctrl = ctrl;
      if (reg_write && reg_addr == EXP_CTRL_ADDR) begin
         next_ctrl = reg_wdata;
      end
      next_reg_rvalid = reg_read;
      next_reg_rdata = reg_rdata;
      if (reg_read) begin
         // unmapped subaddresses read as zero
         next_reg_rdata = (reg_addr == EXP_CTRL_ADDR) ? ctrl : 8'h00;
      end

      // pixel divider and the half-rate reference
      next_pix_cnt = pix_en ? pix_cnt + 3'h1 : pix_cnt;
      next_half = pix_en ? !half_rate_reference : half_rate_reference;

      // sync pulse counter restarts at every line
      next_horiz_valid_ref_prev = horiz_valid_ref;
      next_hs_step = hs_step;
      if (line_start) begin
         next_hs_step = 8'h00;
      end else if (eighth_tick && hs_step != HS_STEP_MAX) begin
         next_hs_step = hs_step + 8'h01;
      end
      next_hs_pipe = half_tick ? {hs_pipe[1:0], hs_raw} : hs_pipe;

      // format selector feeding the buffer
      link.in_valid = 1'b0;
      link.in_data = 8'h00;
      case (fmt)
         FMT_ITU656: begin
            link.in_valid = vid_valid;
            link.in_data = vid_data;
         end
         FMT_GATED: begin
            // timing codes stay; video outside the window is blanked
            link.in_valid = vid_valid;
            link.in_data = (vid_timing_code || gate_on) ? vid_data :
                           (blank_phase ? BLANK_LUMA : BLANK_CHROMA);
         end
         FMT_422: begin
            link.in_valid = vid_valid && !vid_timing_code;
            link.in_data = vid_data;
         end
         FMT_BYP_HI: begin
            link.in_valid = pix_en;
            link.in_data = bypass_byte((two_converters &&
               half_rate_reference) ? conv_hi : conv_lo, 1'b1);
         end
         FMT_BYP_LO: begin
            link.in_valid = pix_en;
            link.in_data = bypass_byte((two_converters &&
               half_rate_reference) ? conv_hi : conv_lo, 1'b0);
         end
         FMT_BYP_SPLIT: begin
            link.in_valid = pix_en;
            link.in_data = bypass_byte(conv_lo, half_rate_reference);
         end
         default: begin
            // reserved codes put nothing on the bus
            link.in_valid = 1'b0;
         end
      endcase

      // blanking alternates chroma/luma, realigned at each timing code
      next_blank_phase = blank_phase;
      if (fmt == FMT_GATED && vid_valid && link.in_ready) begin
         next_blank_phase = vid_timing_code ? 1'b0 : !blank_phase;
      end

      // drain side: the port partner can stall the buffer
      link.out_ready = exp_ready;
      next_exp_valid = link.out_valid && exp_ready;
      next_exp_data = next_exp_valid ? link.out_data : exp_data_bus;

      // pin selections
      next_horiz_valid_ref_out = ctrl[HORIZ_VALID_REF_SEL_BIT] ? hs_sel : horiz_valid_ref;
      case (ctrl[VREF_SEL_HI:VREF_SEL_LO])
         VREF_VSYNC: next_vref_out = vertical_sync_signal;
         VREF_FIELD: next_vref_out = field_identifier;
         VREF_VSYNC_N: next_vref_out = !vertical_sync_signal;
         VREF_FIELD_N: next_vref_out = !field_identifier;
         default: next_vref_out = vertical_sync_signal;
      endcase
      next_lock = ctrl[LOCK_SEL_BIT] ? fast_lock_indicator :
                  !horiz_lock_status;
      next_rt_out = rt_control_data;
      next_rt_oe = ctrl[OUT_EN_BIT];
   end

   // source stalls when the buffer is full; bypass words are then lost
   assign vid_ready = link.in_ready;

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl <= EXP_CTRL_RESET;
         pix_cnt <= 3'h0;
         horiz_valid_ref_prev <= 1'b0;
         hs_step <= 8'h00;
         hs_pipe <= 3'h0;
         blank_phase <= 1'b0;
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
         exp_data_bus <= 8'h00;
         exp_data_valid <= 1'b0;
         exp_horiz_ref_out <= 1'b0;
         exp_vert_ref_out <= 1'b0;
         horiz_lock_indicator <= 1'b0;
         realtime_control_out <= 1'b0;
         realtime_out_oe <= 1'b0;
         half_rate_reference <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         pix_cnt <= next_pix_cnt;
         horiz_valid_ref_prev <= next_horiz_valid_ref_prev;
         hs_step <= next_hs_step;
         hs_pipe <= next_hs_pipe;
         blank_phase <= next_blank_phase;
         reg_rdata <= next_reg_rdata;
         reg_rvalid <= next_reg_rvalid;
         exp_data_bus <= next_exp_data;
         exp_data_valid <= next_exp_valid;
         exp_horiz_ref_out <= next_horiz_valid_ref_out;
         exp_vert_ref_out <= next_vref_out;
         horiz_lock_indicator <= next_lock;
         realtime_control_out <= next_rt_out;
         realtime_out_oe <= next_rt_oe;
         half_rate_reference <= next_half;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_ctrl_write;
      reg_write && reg_addr == EXP_CTRL_ADDR;
   endsequence
   sequence s_ctrl_read;
      reg_read && !reg_write && reg_addr == EXP_CTRL_ADDR;
   endsequence
   sequence s_pop;
      link.out_valid && exp_ready;
   endsequence

   property p_oe_follows;
      1'b1 |=> realtime_out_oe == $past(ctrl[OUT_EN_BIT]);
   endproperty
   a_oe_follows: assert property (p_oe_follows)
      else $error("realtime enable does not follow control bit");

   property p_horiz_valid_ref_select;
      1'b1 |=> exp_horiz_ref_out ==
         $past(ctrl[HORIZ_VALID_REF_SEL_BIT] ? hs_sel : horiz_valid_ref);
   endproperty
   a_horiz_valid_ref_select: assert property (p_horiz_valid_ref_select)
      else $error("horizontal reference output wrong source");

   property p_hs_restart;
      line_start |=> hs_step == 8'h00;
   endproperty
   a_hs_restart: assert property (p_hs_restart)
      else $error("sync step counter not restarted at line start");

   property p_vref_inverted;
      ctrl[VREF_SEL_HI:VREF_SEL_LO] == VREF_VSYNC_N
         |=> exp_vert_ref_out == !$past(vertical_sync_signal);
   endproperty
   a_vref_inverted: assert property (p_vref_inverted)
      else $error("inverted vertical sync not routed");

   property p_lock_std;
      !ctrl[LOCK_SEL_BIT]
         |=> horiz_lock_indicator == !$past(horiz_lock_status);
   endproperty
   a_lock_std: assert property (p_lock_std)
      else $error("standard lock indicator not inverted status");

   property p_itu_pass;
      fmt == FMT_ITU656 && vid_valid |-> link.in_valid &&
         link.in_data == vid_data;
   endproperty
   a_itu_pass: assert property (p_itu_pass)
      else $error("stream byte not passed in standard format");

   property p_no_codes;
      fmt == FMT_422 && vid_timing_code |-> !link.in_valid;
   endproperty
   a_no_codes: assert property (p_no_codes)
      else $error("timing code passed in plain 4:2:2 format");

   property p_byp_pair;
      fmt == FMT_BYP_HI && two_converters && half_rate_reference && pix_en
         |-> link.in_data == conv_hi[8:1];
   endproperty
   a_byp_pair: assert property (p_byp_pair)
      else $error("second converter not output at reference high");

   property p_split_low;
      fmt == FMT_BYP_SPLIT && !half_rate_reference && pix_en
         |-> link.in_data == conv_lo[7:0];
   endproperty
   a_split_low: assert property (p_split_low)
      else $error("low converter bits not output at reference low");

   property p_half_toggle;
      pix_en |=> half_rate_reference != $past(half_rate_reference);
   endproperty
   a_half_toggle: assert property (p_half_toggle)
      else $error("half-rate reference did not toggle");

   property p_readback;
      s_ctrl_write ##1 s_ctrl_read |=> reg_rvalid &&
         reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_readback: assert property (p_readback)
      else $error("control register read differs from write");

   property p_drain;
      s_pop |=> exp_data_valid && exp_data_bus == $past(link.out_data);
   endproperty
   a_drain: assert property (p_drain)
      else $error("buffered word not presented on expansion bus");
endmodule

// *** design/xpc_pkg.sv ***
package xpc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register placement and reset value
   localparam logic [7:0] EXP_CTRL_ADDR = 8'h13;
   localparam logic [7:0] EXP_CTRL_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // field positions inside the control register
   localparam int OUT_EN_BIT = 7;   // realtime output enable
   localparam int HORIZ_VALID_REF_SEL_BIT = 6; // horizontal reference select
   localparam int VREF_SEL_HI = 5;  // vertical reference select, msb
   localparam int VREF_SEL_LO = 4;  // vertical reference select, lsb
   localparam int LOCK_SEL_BIT = 3; // lock indicator variant
   localparam int FMT_HI = 2;       // output format select, msb
   localparam int FMT_LO = 0;       // output format select, lsb

   ////////////////////////////////////////////////////////////////////////
   // output format codes
   localparam logic [2:0] FMT_ITU656 = 3'h0;
   localparam logic [2:0] FMT_GATED = 3'h1;
   localparam logic [2:0] FMT_422 = 3'h2;
   localparam logic [2:0] FMT_RES_A = 3'h3;
   localparam logic [2:0] FMT_BYP_HI = 3'h4;
   localparam logic [2:0] FMT_BYP_LO = 3'h5;
   localparam logic [2:0] FMT_RES_B = 3'h6;
   localparam logic [2:0] FMT_BYP_SPLIT = 3'h7;

   // vertical reference select codes
   localparam logic [1:0] VREF_VSYNC = 2'h0;
   localparam logic [1:0] VREF_FIELD = 2'h1;
   localparam logic [1:0] VREF_VSYNC_N = 2'h2;
   localparam logic [1:0] VREF_FIELD_N = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // timing: pixel ticks per eighth-rate step, last index of the divider
   localparam logic [2:0] EIGHTH_LAST = 3'h7;
   localparam logic [7:0] HS_STEP_MAX = 8'hff;

   // blanking words written over gated-off video
   localparam logic [7:0] BLANK_CHROMA = 8'h80;
   localparam logic [7:0] BLANK_LUMA = 8'h10;

   // output buffer shape
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 8;

   // picks bits 8..1 (high) or 7..0 (low) of a 9-bit converter word
   function automatic logic [7:0] bypass_byte(input logic [8:0] word,
                                              input logic high);
      bypass_byte = high ? word[8:1] : word[7:0];
   endfunction

endpackage

// *** design/xpc_fifo_if.sv ***
`timescale 1ns/10ps
// byte stream between the format selector and the output buffer
interface xpc_fifo_if #(parameter int WIDTH = 8);
   logic in_valid;            // filling side offers a word
   logic in_ready;            // buffer has room
   logic [WIDTH-1:0] in_data; // word offered
   logic out_valid;           // buffer holds a word
   logic out_ready;           // draining side takes it
   logic [WIDTH-1:0] out_data; // oldest word

   modport fifo (input in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready,
                 input in_ready, out_valid, out_data);
endinterface

// *** design/xpc_fifo.sv ***
`timescale 1ns/10ps
module xpc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // stream in and out
   xpc_fifo_if.fifo link
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_N = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];       // storage, indexed by pointer
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [AW-1:0] wptr, next_wptr;      // next slot to fill
   logic [AW-1:0] rptr, next_rptr;      // oldest slot
   logic [AW:0] count, next_count;      // words held
   logic full, next_full;               // registered so ready is clean
   logic empty, next_empty;
   logic push, pop;

   // flags come from flops, so ready and valid never ripple through
   assign link.in_ready = !full;
   assign link.out_valid = !empty;
   assign link.out_data = mem[rptr];

   ////////////////////////////////////////////////////////////////////////
   // next state of pointers, count and storage
   always_comb begin
      push = link.in_valid && !full;
      pop = link.out_ready && !empty;
      next_mem = mem;
      next_wptr = wptr;
      next_rptr = rptr;
      next_count = count;
      if (push) begin
         next_mem[wptr] = link.in_data;
         next_wptr = (wptr == LAST) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
         next_rptr = (rptr == LAST) ? '0 : rptr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
      next_full = (next_count == DEPTH_N);
      next_empty = (next_count == '0);
   end

   // storage needs no reset; only control state is cleared
   always_ff @(posedge clock) begin
      mem <= next_mem;
      if (!rst_n) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         full <= 1'b0;
         empty <= 1'b1;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
         full <= next_full;
         empty <= next_empty;
      end
   end
endmodule

// *** tb/xpc_exp_sink.sv ***
`timescale 1ns/10ps
// codec on the expansion port: takes words, may stall or pace itself
module xpc_exp_sink (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // pacing chosen by the bench
   input wire logic stall,
   input wire logic slow,
   // acceptance towards the port
   output logic exp_ready
);
   logic phase = 1'b0; // alternates for the slow pace
   initial exp_ready = 1'b0;
   // ready moves just after the edge so the port never races it
   always @(posedge clock) begin
      phase <= ~phase & rst_n;
      exp_ready <= #1 rst_n & ~stall & (~slow | phase);
   end
endmodule

// *** tb/expansion_port_output_control_tb_top.sv ***
`timescale 1ns/10ps
module expansion_port_output_control_tb_top import xpc_pkg::*;;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, vid_data = 8'h00;
   logic reg_write = 1'b0, reg_read = 1'b0, pix_en = 1'b0;
   logic [7:0] hsync_begin = 8'h00, hsync_stop = 8'h00;
   logic [1:0] hsync_fine_delay = 2'h0;
   logic [8:0] gate_start_line = 9'h00a, gate_stop_line = 9'h014;
   logic [8:0] line_number = 9'h000;
   logic [8:0] conv [4] = '{default: 9'h000}; // converter words
   logic gate_position_select = 1'b0, horiz_valid_ref = 1'b0;
   logic vertical_sync_signal = 1'b0, field_identifier = 1'b0;
   logic horiz_lock_status = 1'b0, fast_lock_indicator = 1'b0;
   logic rt_control_data = 1'b0, vid_valid = 1'b0;
   logic vid_timing_code = 1'b0, converter_pair_high = 1'b0;
   logic two_converters = 1'b0, stall = 1'b0, slow = 1'b0;
   logic ref_m = 1'b0; // model of the half-rate reference
   logic exp_ready, reg_rvalid, vid_ready, exp_data_valid;
   logic [7:0] reg_rdata, exp_data_bus;
   logic exp_horiz_ref_out, exp_vert_ref_out, horiz_lock_indicator;
   logic realtime_control_out, realtime_out_oe, half_rate_reference;
   logic [7:0] got [$], want [$]; // words seen and words expected
   int miscompares = 0, comparisons = 0, n;
   // ctrl, then vsync fid lock fast horiz_valid_ref, then vref lock oe horiz_valid_ref out
   logic [16:0] rows [5] = '{{8'h80, 5'b10101, 4'b1011},
      {8'h10, 5'b10010, 4'b0100}, {8'h28, 5'b11001, 4'b0001},
      {8'hb8, 5'b00111, 4'b1111}, {8'h40, 5'b01101, 4'b0000}};

   ////////////////////////////////////////////////////////////////////
   xpc_expansion_ctrl dut_u (.clock, .rst_n, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata, .reg_rvalid, .hsync_begin,
      .hsync_stop, .hsync_fine_delay, .gate_start_line, .gate_stop_line,
      .gate_position_select, .pix_en, .horiz_valid_ref,
      .vertical_sync_signal, .field_identifier, .line_number,
      .horiz_lock_status, .fast_lock_indicator, .rt_control_data,
      .vid_data, .vid_valid, .vid_timing_code, .vid_ready,
      .converter_one(conv[0]), .converter_two(conv[1]),
      .converter_three(conv[2]), .converter_four(conv[3]),
      .converter_pair_high, .two_converters, .exp_ready, .exp_data_bus,
      .exp_data_valid, .exp_horiz_ref_out, .exp_vert_ref_out,
      .horiz_lock_indicator, .realtime_control_out, .realtime_out_oe,
      .half_rate_reference);
   xpc_exp_sink sink_u (.clock, .rst_n, .stall, .slow, .exp_ready);

   ////////////////////////////////////////////////////////////////////
   // clock and the word collector on the port
   initial forever #4 clock = ~clock;
   always @(posedge clock) begin
      if (exp_data_valid === 1'b1) begin
         got.push_back(exp_data_bus);
      end
   end

   task automatic chk_byte(input logic [7:0] g, e, input string m);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: %s %h not %h", $time, m, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, e, input string m);
      chk_byte({7'h00, g}, {7'h00, e}, m);
   endtask
   // all driving happens 1 ns after an edge
   task automatic tick(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      tick(1);
      reg_write = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, e);
      reg_addr = a;
      reg_read = 1'b1;
      tick(1);
      reg_read = 1'b0;
      chk_bit(reg_rvalid, 1'b1, "read valid");
      chk_byte(reg_rdata, e, "read data");
      tick(1);
   endtask
   // valid stays up between bytes; drain lowers it
   task automatic send(input logic [7:0] d, input logic tc);
      int w;
      vid_data = d;
      vid_timing_code = tc;
      vid_valid = 1'b1;
      w = 0;
      while (vid_ready !== 1'b1 && w < 50) begin
         tick(1);
         w++;
      end
      if (w == 50) chk_bit(1'b0, 1'b1, "stream refused");
      tick(1);
   endtask
   task automatic drain;
      int w;
      vid_valid = 1'b0;
      w = 0;
      while (got.size() < want.size() && w < 200) begin
         tick(1);
         w++;
      end
      tick(4);
      chk_byte(8'(got.size()), 8'(want.size()), "word count");
      foreach (want[i]) begin
         if (i < got.size()) chk_byte(got[i], want[i], "word");
      end
      got.delete();
      want.delete();
   endtask
   // six bytes, every third one a timing code
   task automatic strm(input logic [2:0] f, input logic [8:0] ln,
                       input logic gps);
      logic tc, win, b;
      line_number = ln;
      gate_position_select = gps;
      win = ln >= 9'h00a && (ln < 9'h014 || (gps && ln == 9'h014));
      wr(EXP_CTRL_ADDR, {5'h00, f});
      b = 1'b0;
      for (int i = 0; i < 6; i++) begin
         tc = (i % 3 == 0);
         send(8'h30 + 8'(i), tc);
         if (tc) b = 1'b0;
         // blanking alternates, restarting after each code
         if (!(f == FMT_422 && tc)) want.push_back((f == FMT_GATED
            && !win && !tc) ? (b ? BLANK_LUMA : BLANK_CHROMA)
            : 8'h30 + 8'(i));
         if (!tc) b = ~b;
      end
      drain();
      $display("test stream %0d done", f);
   endtask
   // bypass: the reference before its toggle picks the word
   task automatic byp(input logic [2:0] f, input logic two, hi);
      logic [8:0] wh, wl;
      converter_pair_high = hi;
      two_converters = two;
      wr(EXP_CTRL_ADDR, {5'h00, f});
      for (int k = 0; k < 4; k++) begin
         foreach (conv[j]) conv[j] = 9'(9'h05b * (j + 1) + k * 7);
         wh = hi ? conv[3] : conv[1];
         wl = hi ? conv[2] : conv[0];
         if (f != FMT_BYP_SPLIT && two && ref_m) wl = wh;
         if (f == FMT_BYP_SPLIT) want.push_back(ref_m ? wl[8:1] : wl[7:0]);
         else want.push_back(f == FMT_BYP_HI ? wl[8:1] : wl[7:0]);
         pix_en = 1'b1;
         tick(1);
         pix_en = 1'b0;
         ref_m = ~ref_m;
         tick(1);
         chk_bit(half_rate_reference, ref_m, "half rate ref");
      end
      drain();
      $display("test bypass %0d done", f);
   endtask
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // watchdog: the whole run needs a few hundred cycles
   initial begin
      #100000;
      miscompares++;
      finish_test();
   end
   initial begin
      tick(5);
      rst_n = 1'b1;
      chk_bit(realtime_out_oe, 1'b0, "oe at reset");
      chk_bit(vid_ready, 1'b1, "ready at reset");
      rd(EXP_CTRL_ADDR, EXP_CTRL_RESET);
      $display("test reset done");
      foreach (rows[r]) begin
         {vertical_sync_signal, field_identifier, horiz_lock_status,
          fast_lock_indicator, horiz_valid_ref} = rows[r][8:4];
         rt_control_data = rows[r][6];
         wr(EXP_CTRL_ADDR, rows[r][16:9]);
         rd(EXP_CTRL_ADDR, rows[r][16:9]);
         tick(2);
         chk_bit(exp_vert_ref_out, rows[r][3], "vert ref");
         chk_bit(horiz_lock_indicator, rows[r][2], "lock");
         chk_bit(realtime_out_oe, rows[r][1], "oe");
         chk_bit(exp_horiz_ref_out, rows[r][0], "horiz ref");
         chk_bit(realtime_control_out, rows[r][6], "rt out");
      end
      $display("test row table done");
      // unmapped place: write ignored, read gives zero
      wr(8'h12, 8'hff);
      rd(8'h12, 8'h00);
      rd(EXP_CTRL_ADDR, rows[4][16:9]);
      slow = 1'b1;
      strm(FMT_ITU656, 9'h000, 1'b0);
      slow = 1'b0;
      strm(FMT_GATED, 9'h014, 1'b0);
      strm(FMT_GATED, 9'h014, 1'b1);
      strm(FMT_422, 9'h000, 1'b0);
      // stalled codec: the buffer takes its depth, then refuses
      stall = 1'b1;
      tick(3);
      n = 0;
      while (vid_ready === 1'b1 && n < 12) begin
         send(8'h50 + 8'(n), 1'b0);
         want.push_back(8'h50 + 8'(n));
         n++;
      end
      chk_byte(8'(n), 8'(FIFO_DEPTH), "words before full");
      stall = 1'b0;
      drain();
      $display("test buffer full done");
      // the reserved codes 011 and 110 are never programmed
      byp(FMT_BYP_HI, 1'b1, 1'b0);
      byp(FMT_BYP_HI, 1'b0, 1'b1);
      byp(FMT_BYP_LO, 1'b1, 1'b1);
      byp(FMT_BYP_SPLIT, 1'b0, 1'b0);
      byp(FMT_BYP_SPLIT, 1'b0, 1'b1);
      // sync pulse on from step 1 to step 2; 8 ticks give one step
      wr(EXP_CTRL_ADDR, 8'h40);
      hsync_begin = 8'h01;
      hsync_stop = 8'h02;
      horiz_valid_ref = 1'b0;
      tick(1);
      horiz_valid_ref = 1'b1;
      tick(1);
      pix_en = 1'b1;
      tick(1);
      chk_bit(exp_horiz_ref_out, 1'b0, "sync before begin");
      tick(7);
      pix_en = 1'b0;
      tick(2);
      chk_bit(exp_horiz_ref_out, 1'b1, "sync pulse");
      pix_en = 1'b1;
      tick(8);
      pix_en = 1'b0;
      tick(2);
      chk_bit(exp_horiz_ref_out, 1'b0, "sync after stop");
      $display("test sync pulse done");
      // read on the edge right after a write sees the new value
      reg_addr = EXP_CTRL_ADDR;
      reg_wdata = 8'h5a;
      reg_write = 1'b1;
      tick(1);
      reg_write = 1'b0;
      reg_read = 1'b1;
      tick(1);
      reg_read = 1'b0;
      chk_bit(reg_rvalid, 1'b1, "back to back valid");
      chk_byte(reg_rdata, 8'h5a, "back to back read");
      // second reset in mid-run clears the register
      wr(EXP_CTRL_ADDR, 8'h80);
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      chk_bit(realtime_out_oe, 1'b0, "oe after reset");
      rd(EXP_CTRL_ADDR, EXP_CTRL_RESET);
      $display("test second reset done");
      finish_test();
   end
endmodule
